// >>> logic/fcl_defines.vh
`ifndef FCL_DEFINES_VH
`define FCL_DEFINES_VH

// Register word addresses
`define FCL_ADDR_FB_MODE 16'h0f00
`define FCL_ADDR_FB_TYPE 16'h0f03
`define FCL_ADDR_EXT_PPR 16'h0f04
`define FCL_ADDR_DEV_THR 16'h0f08
`define FCL_ADDR_CLR_REV 16'h0f0a
`define FCL_ADDR_FILT_TIME 16'h0f0d
`define FCL_ADDR_DEV_DISP 16'h0f10
`define FCL_ADDR_INNER_CNT 16'h0f12
`define FCL_ADDR_OUTER_CNT 16'h0f14
`define FCL_ADDR_Z_CHK_DIS 16'h0f16
`define FCL_ADDR_PROBE_SRC 16'h0f19
`define FCL_ADDR_THR_SCALE 16'h0f2d
`define FCL_ADDR_SPD_SEL 16'h0f2e
`define FCL_ADDR_MP_MODE 16'h1100

// Reset values
`define FCL_RST_FB_MODE 16'h0000
`define FCL_RST_FB_TYPE 16'h0000
`define FCL_RST_EXT_PPR 32'h00002710
`define FCL_RST_DEV_THR 32'h000003e8
`define FCL_RST_CLR_REV 16'h0001
`define FCL_RST_FILT_TIME 16'h0000
`define FCL_RST_FLAG 16'h0000
`define FCL_RST_MP_MODE 16'h0001

// Value limits
`define FCL_FB_MODE_MAX 16'h0002
`define FCL_CLR_REV_MAX 16'h0064
`define FCL_PPR_MAX 32'h7fffffff
`define FCL_THR_MAX 32'h7fffffff

// Feedback source modes
`define FCL_FB_INTERNAL 2'h0
`define FCL_FB_EXTERNAL 2'h1
`define FCL_FB_SWITCHED 2'h2

// Multi-position modes
`define FCL_MP_SINGLE 16'h0000
`define FCL_MP_CYCLIC 16'h0001
`define FCL_MP_DI_SEL 16'h0002
`define FCL_MP_SEQUENTIAL 16'h0003
`define FCL_MP_AXIS_CONT 16'h0005

// Motor resolution as power of two, internal pulses per turn
`define FCL_RES_BITS 17

// Filter time unit 0.1 ms, in ns, and its cycle count at 100 ns clock
`define FCL_CLK_PERIOD_NS 100
`define FCL_FILT_UNIT_NS 100000
`define FCL_FILT_TICK_CYC (`FCL_FILT_UNIT_NS / `FCL_CLK_PERIOD_NS)

`endif

// >>> logic/fcl_quad.v
`timescale 1ns/1ns
// Quadrature decoder for the external scale, x4 counting
module fcl_quad (
   input wire clk,
   input wire rst_b,
   input wire quad_a,
   input wire quad_b,
   output reg step_reg,
   output reg dir_reg
);

reg a_reg;
reg b_reg;
wire moved;
wire fwd;

// A change of one phase is one count, both at once none; direction from phase order
assign moved = (quad_a ^ a_reg) | (quad_b ^ b_reg);
assign fwd = quad_a ^ b_reg;

////////////////////////////////////////////////////////////////////////
// Previous phase state and step output
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      step_reg <= 1'b0;
      dir_reg <= 1'b0;
   end else begin
      a_reg <= quad_a;
      b_reg <= quad_b;
      step_reg <= moved & ~((quad_a ^ a_reg) & (quad_b ^ b_reg));
      dir_reg <= fwd;
   end
end

endmodule // fcl_quad

// >>> logic/fcl_top.v
`timescale 1ns/1ns
`include "fcl_defines.vh"
// What this block does
// - Feedback type accepts only quadrature value 0
// - Scale pulses per motor turn, default 10000
// - Deviation above threshold raises closed-loop fault
// - Threshold zero: no fault, deviation kept cleared
// - Clear deviation every configured motor revolutions
// - Revolution count held while not operational
// - Vibration filter only with external feedback
// - Deviation is outer minus converted inner position
// - Signed inner pulse counter after gearing
// - Signed outer pulse counter after gearing
// - Scale index checked at 0, ignored at 1
// - Probe index from motor or scale
// - Thresholds scaled to outer loop or shared
// - Speed feedback from inner or outer encoder
// - Multi-position mode codes 0,1,2,3,5, default 1
// - Position feedback internal, external or input-switched
module fcl_top (
   input wire clk,
   input wire rst_b,
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata_reg,
   output reg reg_ack_reg,
   input wire servo_running,
   input wire fault_reset,
   input wire inner_step,
   input wire inner_dir,
   input wire quad_a,
   input wire quad_b,
   input wire ext_z,
   input wire motor_z,
   input wire gear_ratio_switch_input,
   output reg excess_loop_deviation_fault_reg,
   output reg ext_z_event_reg,
   output reg probe_z_reg,
   output reg pos_fb_external_reg,
   output reg speed_fb_external_reg,
   output reg thr_shared_reg,
   output reg filter_active_reg,
   output reg [31:0] filtered_dev_reg,
   output reg [15:0] mp_mode_out_reg
);

reg [1:0] fb_mode_reg;
reg [15:0] fb_type_reg;
reg [31:0] ext_ppr_reg;
reg [31:0] dev_thr_reg;
reg [15:0] clr_rev_reg;
reg [15:0] filt_time_reg;
reg z_chk_dis_reg;
reg probe_src_reg;
reg thr_scale_reg;
reg spd_sel_reg;
reg [15:0] mp_mode_reg;
reg [31:0] inner_cnt_reg;
reg [31:0] outer_cnt_reg;
reg [31:0] inner_base_reg;
reg [31:0] outer_base_reg;
reg [31:0] dev_reg;
reg [`FCL_RES_BITS-1:0] turn_pos_reg;
reg [15:0] rev_cnt_reg;
reg [15:0] tick_cnt_reg;
reg [15:0] filt_cnt_reg;
wire ext_step;
wire ext_dir;
wire wr_stopped;
wire [31:0] inner_delta;
wire [63:0] conv_prod;
wire [31:0] conv_delta;
wire [31:0] dev_next;
wire [31:0] dev_abs;
wire over_thr;
wire rev_done;
wire turn_wrap;
wire clr_now;
wire use_ext;
wire filt_tick;
wire [31:0] filt_diff;

////////////////////////////////////////////////////////////////////////
// Scale quadrature decoding
fcl_quad u_quad (
   .clk(clk),
   .rst_b(rst_b),
   .quad_a(quad_a),
   .quad_b(quad_b),
   .step_reg(ext_step),
   .dir_reg(ext_dir)
);

// Writes to stop-only settings are taken only while stopped
assign wr_stopped = reg_wr & ~servo_running;

////////////////////////////////////////////////////////////////////////
// Writable settings
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      fb_mode_reg <= `FCL_FB_INTERNAL;
      fb_type_reg <= `FCL_RST_FB_TYPE;
      ext_ppr_reg <= `FCL_RST_EXT_PPR;
      dev_thr_reg <= `FCL_RST_DEV_THR;
      clr_rev_reg <= `FCL_RST_CLR_REV;
      filt_time_reg <= `FCL_RST_FILT_TIME;
      z_chk_dis_reg <= 1'b0;
      probe_src_reg <= 1'b0;
      thr_scale_reg <= 1'b0;
      spd_sel_reg <= 1'b0;
      mp_mode_reg <= `FCL_RST_MP_MODE;
   end else begin
      if (reg_wr && reg_addr == `FCL_ADDR_FB_MODE &&
          reg_wdata[15:0] <= `FCL_FB_MODE_MAX) begin
         fb_mode_reg <= reg_wdata[1:0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_FB_TYPE && reg_wdata[15:0] == 16'h0000) begin
         fb_type_reg <= reg_wdata[15:0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_EXT_PPR && reg_wdata <= `FCL_PPR_MAX) begin
         ext_ppr_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FCL_ADDR_DEV_THR && reg_wdata <= `FCL_THR_MAX) begin
         dev_thr_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FCL_ADDR_CLR_REV &&
          reg_wdata[15:0] <= `FCL_CLR_REV_MAX) begin
         clr_rev_reg <= reg_wdata[15:0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_FILT_TIME) begin
         filt_time_reg <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `FCL_ADDR_Z_CHK_DIS && reg_wdata[15:1] == 15'h0000) begin
         z_chk_dis_reg <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == `FCL_ADDR_PROBE_SRC && reg_wdata[15:1] == 15'h0000) begin
         probe_src_reg <= reg_wdata[0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_THR_SCALE && reg_wdata[15:1] == 15'h0000) begin
         thr_scale_reg <= reg_wdata[0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_SPD_SEL && reg_wdata[15:1] == 15'h0000) begin
         spd_sel_reg <= reg_wdata[0];
      end
      if (wr_stopped && reg_addr == `FCL_ADDR_MP_MODE &&
          (reg_wdata[15:0] == `FCL_MP_SINGLE || reg_wdata[15:0] == `FCL_MP_CYCLIC ||
           reg_wdata[15:0] == `FCL_MP_DI_SEL || reg_wdata[15:0] == `FCL_MP_SEQUENTIAL ||
           reg_wdata[15:0] == `FCL_MP_AXIS_CONT)) begin
         mp_mode_reg <= reg_wdata[15:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Deviation arithmetic
assign inner_delta = inner_cnt_reg - inner_base_reg;
// inner movement converted to scale units
assign conv_prod = $signed({{32{inner_delta[31]}}, inner_delta}) *
                   $signed({32'h00000000, ext_ppr_reg});
assign conv_delta = conv_prod[`FCL_RES_BITS+31:`FCL_RES_BITS];
assign dev_next = (outer_cnt_reg - outer_base_reg) - conv_delta;
assign dev_abs = dev_reg[31] ? (32'h00000000 - dev_reg) : dev_reg;
assign over_thr = (dev_thr_reg != 32'h00000000) && (dev_abs > dev_thr_reg);
assign rev_done = servo_running && (clr_rev_reg != 16'h0000) && (rev_cnt_reg >= clr_rev_reg);
assign turn_wrap = servo_running && inner_step && (&turn_pos_reg);
assign clr_now = rev_done || (dev_thr_reg == 32'h00000000);

////////////////////////////////////////////////////////////////////////
// Pulse counters, bases and deviation
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      inner_cnt_reg <= 32'h00000000;
      outer_cnt_reg <= 32'h00000000;
      inner_base_reg <= 32'h00000000;
      outer_base_reg <= 32'h00000000;
      dev_reg <= 32'h00000000;
   end else begin
      if (inner_step) begin
         inner_cnt_reg <= inner_dir ? inner_cnt_reg - 32'h00000001 :
                          inner_cnt_reg + 32'h00000001;
      end
      if (ext_step) begin
         outer_cnt_reg <= ext_dir ? outer_cnt_reg + 32'h00000001 :
                          outer_cnt_reg - 32'h00000001;
      end
      if (clr_now) begin
         inner_base_reg <= inner_cnt_reg;
         outer_base_reg <= outer_cnt_reg;
         dev_reg <= 32'h00000000;
      end else begin
         dev_reg <= dev_next;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Motor revolution accounting
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      turn_pos_reg <= {`FCL_RES_BITS{1'b0}};
      rev_cnt_reg <= 16'h0000;
   end else begin
      // counted only when running, never reset
      if (servo_running && inner_step) begin
         turn_pos_reg <= turn_pos_reg + {{(`FCL_RES_BITS-1){1'b0}}, 1'b1};
      end
      if (rev_done) begin
         // restart at each clear, a turn ending now still counts
         rev_cnt_reg <= {15'h0000, turn_wrap};
      end else if (turn_wrap) begin
         rev_cnt_reg <= rev_cnt_reg + 16'h0001;
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Fault latch, set wins over reset
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      excess_loop_deviation_fault_reg <= 1'b0;
   end else if (over_thr) begin
      excess_loop_deviation_fault_reg <= 1'b1;
   end else if (fault_reset) begin
      excess_loop_deviation_fault_reg <= 1'b0;
   end
end

assign use_ext = (fb_mode_reg == `FCL_FB_EXTERNAL) ||
                 (fb_mode_reg == `FCL_FB_SWITCHED && gear_ratio_switch_input);

////////////////////////////////////////////////////////////////////////
// Source selects and index routing
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      pos_fb_external_reg <= 1'b0;
      speed_fb_external_reg <= 1'b0;
      thr_shared_reg <= 1'b0;
      probe_z_reg <= 1'b0;
      ext_z_event_reg <= 1'b0;
      mp_mode_out_reg <= `FCL_RST_MP_MODE;
   end else begin
      pos_fb_external_reg <= use_ext;
      speed_fb_external_reg <= (fb_mode_reg != `FCL_FB_INTERNAL) & spd_sel_reg;
      thr_shared_reg <= (fb_mode_reg != `FCL_FB_INTERNAL) & thr_scale_reg;
      probe_z_reg <= (probe_src_reg && fb_mode_reg != `FCL_FB_INTERNAL) ? ext_z : motor_z;
      ext_z_event_reg <= ext_z & ~z_chk_dis_reg;
      mp_mode_out_reg <= mp_mode_reg;
   end
end

////////////////////////////////////////////////////////////////////////
// Vibration filter tick, one per 0.1 ms
assign filt_tick = (tick_cnt_reg == `FCL_FILT_TICK_CYC - 1);
assign filt_diff = dev_reg - filtered_dev_reg;

always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      tick_cnt_reg <= 16'h0000;
      filt_cnt_reg <= 16'h0000;
      filter_active_reg <= 1'b0;
      filtered_dev_reg <= 32'h00000000;
   end else begin
      tick_cnt_reg <= filt_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      // only with scale feedback, zero disables
      filter_active_reg <= use_ext && (filt_time_reg != 16'h0000);
      if (!filter_active_reg) begin
         filtered_dev_reg <= dev_reg;
         filt_cnt_reg <= 16'h0000;
      end else if (filt_tick) begin
         // First-order lag: one sixteenth step per time constant
         if (filt_cnt_reg >= filt_time_reg - 16'h0001) begin
            filt_cnt_reg <= 16'h0000;
            filtered_dev_reg <= filtered_dev_reg + {{4{filt_diff[31]}}, filt_diff[31:4]} +
                                {31'h00000000, (filt_diff[31:4] == 28'h0000000) &
                                 (filt_diff != 32'h00000000)};
         end else begin
            filt_cnt_reg <= filt_cnt_reg + 16'h0001;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Register read port, one cycle latency
always @(posedge clk or negedge rst_b) begin
   if (!rst_b) begin
      reg_rdata_reg <= 32'h00000000;
      reg_ack_reg <= 1'b0;
   end else begin
      reg_ack_reg <= reg_rd | reg_wr;
      if (reg_rd) begin
         case (reg_addr)
            `FCL_ADDR_FB_MODE: reg_rdata_reg <= {30'h00000000, fb_mode_reg};
            `FCL_ADDR_FB_TYPE: reg_rdata_reg <= {16'h0000, fb_type_reg};
            `FCL_ADDR_EXT_PPR: reg_rdata_reg <= ext_ppr_reg;
            `FCL_ADDR_DEV_THR: reg_rdata_reg <= dev_thr_reg;
            `FCL_ADDR_CLR_REV: reg_rdata_reg <= {16'h0000, clr_rev_reg};
            `FCL_ADDR_FILT_TIME: reg_rdata_reg <= {16'h0000, filt_time_reg};
            `FCL_ADDR_DEV_DISP: reg_rdata_reg <= dev_reg;
            `FCL_ADDR_INNER_CNT: reg_rdata_reg <= inner_cnt_reg;
            `FCL_ADDR_OUTER_CNT: reg_rdata_reg <= outer_cnt_reg;
            `FCL_ADDR_Z_CHK_DIS: reg_rdata_reg <= {31'h00000000, z_chk_dis_reg};
            `FCL_ADDR_PROBE_SRC: reg_rdata_reg <= {31'h00000000, probe_src_reg};
            `FCL_ADDR_THR_SCALE: reg_rdata_reg <= {31'h00000000, thr_scale_reg};
            `FCL_ADDR_SPD_SEL: reg_rdata_reg <= {31'h00000000, spd_sel_reg};
            `FCL_ADDR_MP_MODE: reg_rdata_reg <= {16'h0000, mp_mode_reg};
            default: reg_rdata_reg <= 32'h00000000;
         endcase
      end
   end
end

endmodule // fcl_top

// >>> tb/fcl_enc_model.sv
`timescale 1ns/1ns
// Motor encoder and quadrature scale seen by the drive
module fcl_enc_model (
   input wire clk,
   output logic inner_step,
   output logic inner_dir,
   output wire quad_a,
   output wire quad_b,
   output logic ext_z,
   output logic motor_z
);
   logic [1:0] phase_reg;
   // Idle encoders at time zero
   initial begin
      inner_step = 1'b0;
      inner_dir = 1'b0;
      ext_z = 1'b0;
      motor_z = 1'b0;
      phase_reg = 2'h0;
   end
   // Gray phases, a leads b on upward travel
   assign quad_a = phase_reg == 2'h1 || phase_reg == 2'h2;
   assign quad_b = phase_reg[1];
   // Scale travel, gap sets how slow the edges come
   task scale_move(input int n, input logic down, input int gap);
      repeat (n) begin
         @(posedge clk);
         #10 phase_reg = down ? phase_reg - 2'h1 : phase_reg + 2'h1;
         repeat (gap) @(posedge clk);
      end
   endtask
   // Back-to-back motor pulses
   task motor_move(input int n, input logic down);
      @(posedge clk);
      #10 inner_dir = down;
      inner_step = 1'b1;
      repeat (n) @(posedge clk);
      #10 inner_step = 1'b0;
   endtask
   // Index levels
   task index(input logic ez, input logic mz);
      ext_z = ez;
      motor_z = mz;
   endtask
endmodule // fcl_enc_model

// >>> tb/fcl_monitor.sv
`timescale 1ns/1ns
// Port-level checks on the closed-loop supervisor
module fcl_monitor (
   input wire clk,
   input wire rst_b,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata_reg,
   input wire reg_ack_reg,
   input wire servo_running,
   input wire fault_reset,
   input wire ext_z,
   input wire motor_z,
   input wire excess_loop_deviation_fault_reg,
   input wire ext_z_event_reg,
   input wire probe_z_reg,
   input wire [15:0] mp_mode_out_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Register port steps
   sequence s_strobe;
      reg_wr || reg_rd;
   endsequence
   sequence s_idle;
      !reg_wr && !reg_rd;
   endsequence
   sequence s_stopped_run;
      servo_running [*2];
   endsequence
   a_ack_follows: assert property (s_strobe |=> reg_ack_reg)
      else $error("no ack after strobe");
   a_ack_spurious: assert property (s_idle |=> !reg_ack_reg)
      else $error("ack without strobe");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_reg))
      else $error("read data moved without read");
   ////////////////////////////////////////
   // Fault latch and signal routing
   a_fault_latched: assert property (
      excess_loop_deviation_fault_reg && !fault_reset |=> excess_loop_deviation_fault_reg)
      else $error("fault dropped without reset");
   a_fault_release: assert property (
      $fell(excess_loop_deviation_fault_reg) |-> $past(fault_reset))
      else $error("fault cleared without fault reset");
   a_scale_index_gate: assert property (ext_z_event_reg |-> $past(ext_z))
      else $error("index event without scale index");
   a_probe_source: assert property (1'b1 |=>
      probe_z_reg == $past(motor_z) || probe_z_reg == $past(ext_z))
      else $error("probe index from no source");
   a_mode_code_legal: assert property (
      mp_mode_out_reg inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005})
      else $error("illegal multi-position mode");
   a_mode_frozen_run: assert property (s_stopped_run |=> $stable(mp_mode_out_reg))
      else $error("mode changed while running");
endmodule // fcl_monitor

bind fcl_top fcl_monitor u_fcl_monitor (.clk, .rst_b, .reg_wr, .reg_rd, .reg_rdata_reg,
   .reg_ack_reg, .servo_running, .fault_reset, .ext_z, .motor_z,
   .excess_loop_deviation_fault_reg, .ext_z_event_reg, .probe_z_reg, .mp_mode_out_reg);

// >>> tb/tb_full_closed_loop_feedback.sv
`timescale 1ns/1ns
module tb_full_closed_loop_feedback;
   logic clk = 1'b0, rst_b, reg_wr, reg_rd, servo_running, fault_reset, gear_sel;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata;
   wire [31:0] rdata, fdev;
   wire [15:0] mp_out;
   wire ack, istep, idir, qa, qb, ez, mz, fault, zev, probe, posx, spdx, shared, filt;
   int num_errors = 0, n_checks = 0, i;
   logic [15:0] addr_t [15] = '{16'h0f00, 16'h0f03, 16'h0f04, 16'h0f08, 16'h0f0a, 16'h0f0d,
      16'h0f10, 16'h0f12, 16'h0f14, 16'h0f16, 16'h0f19, 16'h0f2d, 16'h0f2e, 16'h1100, 16'h0fff};
   logic [31:0] rst_t [15] = '{0, 0, 32'h2710, 32'h3e8, 1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0};
   // 10 MHz clock
   always #50 clk = ~clk;
   fcl_top u_fcl_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_reg(rdata), .reg_ack_reg(ack),
      .servo_running(servo_running), .fault_reset(fault_reset), .inner_step(istep),
      .inner_dir(idir), .quad_a(qa), .quad_b(qb), .ext_z(ez), .motor_z(mz),
      .gear_ratio_switch_input(gear_sel), .excess_loop_deviation_fault_reg(fault),
      .ext_z_event_reg(zev), .probe_z_reg(probe), .pos_fb_external_reg(posx),
      .speed_fb_external_reg(spdx), .thr_shared_reg(shared), .filter_active_reg(filt),
      .filtered_dev_reg(fdev), .mp_mode_out_reg(mp_out));
   fcl_enc_model u_fcl_enc_model (.clk(clk), .inner_step(istep), .inner_dir(idir),
      .quad_a(qa), .quad_b(qb), .ext_z(ez), .motor_z(mz));
   ////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task flag(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      #10 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #10 reg_wr = 1'b0;
      flag(ack, 1'b1);
   endtask
   task rchk(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      #10 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #10 reg_rd = 1'b0;
      flag(ack, 1'b1);
      chk(rdata, exp);
   endtask
   task pulse_fr;
      @(posedge clk);
      #10 fault_reset = 1'b1;
      tick(1);
      fault_reset = 1'b0;
      tick(2);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   // Watchdog
   initial begin
      #2000000;
      num_errors++;
      end_sim;
   end
   // Test sequence
   initial begin
      {rst_b, reg_wr, reg_rd, servo_running, fault_reset, gear_sel} = 6'h00;
      reg_addr = 16'h0000;
      reg_wdata = 32'h00000000;
      repeat (5) @(posedge clk);
      #10 rst_b = 1'b1;
      for (i = 0; i < 15; i++) rchk(addr_t[i], rst_t[i]);
      wr(16'h0f03, 1); rchk(16'h0f03, 0);
      wr(16'h0f04, 32'h80000000); rchk(16'h0f04, 32'h2710);
      wr(16'h0f04, 32'h20000); rchk(16'h0f04, 32'h20000);
      wr(16'h0f0a, 101); rchk(16'h0f0a, 1);
      wr(16'h0f0a, 100); rchk(16'h0f0a, 100);
      wr(16'h0f10, 5); rchk(16'h0f10, 0);
      for (i = 0; i < 6; i++) begin
         wr(16'h1100, i); rchk(16'h1100, i == 4 ? 3 : i);
         tick(2); chk({16'h0, mp_out}, i == 4 ? 3 : i);
      end
      servo_running = 1'b1;
      wr(16'h1100, 2); rchk(16'h1100, 5);
      tick(2); chk({16'h0, mp_out}, 5);
      wr(16'h0f04, 32'h10); rchk(16'h0f04, 32'h20000);
      $display("test registers done");
      u_fcl_enc_model.motor_move(10, 1'b0);
      u_fcl_enc_model.motor_move(3, 1'b1);
      u_fcl_enc_model.scale_move(6, 1'b0, 2);
      tick(6);
      rchk(16'h0f12, 7);
      rchk(16'h0f14, 6);
      rchk(16'h0f10, 32'hffffffff);
      chk(fdev, 32'hffffffff);
      $display("test counting done");
      wr(16'h0f08, 3); u_fcl_enc_model.scale_move(4, 1'b0, 5);
      tick(6); flag(fault, 1'b0);
      u_fcl_enc_model.scale_move(1, 1'b0, 2);
      tick(6); flag(fault, 1'b1);
      pulse_fr; flag(fault, 1'b1);
      u_fcl_enc_model.scale_move(2, 1'b1, 2);
      tick(6); pulse_fr; flag(fault, 1'b0);
      u_fcl_enc_model.scale_move(6, 1'b1, 2);
      tick(6); flag(fault, 1'b1);
      wr(16'h0f08, 0); tick(3); rchk(16'h0f10, 0);
      pulse_fr; u_fcl_enc_model.scale_move(5, 1'b0, 2);
      tick(6); flag(fault, 1'b0);
      rchk(16'h0f10, 0);
      $display("test fault done");
      servo_running = 1'b0;
      wr(16'h0f00, 1); tick(2); flag(posx, 1'b1);
      wr(16'h0f00, 2); tick(2); flag(posx, 1'b0);
      gear_sel = 1'b1; tick(2); flag(posx, 1'b1);
      u_fcl_enc_model.index(1'b1, 1'b0);
      wr(16'h0f19, 1); tick(2); flag(probe, 1'b1);
      flag(zev, 1'b1);
      wr(16'h0f19, 0); tick(2); flag(probe, 1'b0);
      wr(16'h0f16, 1); tick(2); flag(zev, 1'b0);
      wr(16'h0f2e, 1); wr(16'h0f2d, 1); tick(3);
      flag(filt, 1'b0);
      wr(16'h0f0d, 1); tick(3);
      flag(spdx, 1'b1);
      flag(shared, 1'b1);
      flag(filt, 1'b1);
      // Filtered deviation lags a step of 16 counts, one count per tick
      wr(16'h0f08, 1000);
      u_fcl_enc_model.scale_move(16, 1'b0, 0);
      tick(3);
      rchk(16'h0f10, 16);
      flag(fdev <= 32'h00000001, 1'b1);
      tick(1000);
      flag(fdev == 32'h00000001 || fdev == 32'h00000002, 1'b1);
      wr(16'h0f00, 0); tick(3); flag(filt, 1'b0);
      chk(fdev, 32'h00000010);
      flag(spdx, 1'b0);
      $display("test selects done");
      end_sim;
   end
endmodule // tb_full_closed_loop_feedback
